// file: hdl/rwm_top.sv
// Relay channel sequencer: digital output or sensor warm-up against bursts.
// Assumes register strobes and i_sample come from logic on i_sys_clk.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module rwm_top #(
    parameter int P_TICK_CYCLES = rwm_pkg::TICK_CYCLES,
    parameter int P_DW = 16,
    parameter int P_NS = 8
) (
    input wire logic i_sys_clk,                        // 100 MHz clock
    input wire logic i_rst_n,                          // Async reset, active low
    input wire logic [rwm_pkg::ADDR_W-1:0] i_addr,     // Register byte address
    input wire logic [rwm_pkg::DATA_W-1:0] i_wdata,    // Write data
    input wire logic i_wr,                             // Write strobe
    input wire logic i_rd,                             // Read strobe
    output logic [rwm_pkg::DATA_W-1:0] o_rdata,        // Read data, next cycle
    input wire logic [P_DW-1:0] i_sample,              // Converted sensor value
    output logic o_relay,                              // Relay or sensor supply
    output logic o_rec_valid,                          // Record pulse
    output logic [P_DW-1:0] o_rec_value                // Recorded median
);
    import rwm_pkg::*;
    localparam int SW = P_DW + TIME_W;
    localparam int CW = $clog2(P_NS + 1);
    localparam int TCW = $clog2(P_TICK_CYCLES + 1);
    if (P_NS < 2 || (P_NS & (P_NS - 1)) != 0 || P_DW < 2 || P_DW > DATA_W ||
        P_TICK_CYCLES < 2) begin : g_chk
        $error("rwm_top: unsupported parameter values");
    end
    rwm_div_if #(.W(SW)) div_bus ();
    rwm_div #(.W(SW)) u_div (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .bus(div_bus)
    );
    // ****************************************
    // State
    // ****************************************
    rwm_mode_t mode_r, mode_nxt;
    logic setp_r, setp_nxt, inv_r, inv_nxt;
    logic [TIME_W-1:0] lead_r, lead_nxt, cyc_r, cyc_nxt, blen_r, blen_nxt, rec_r, rec_nxt;
    logic [TIME_W-1:0] decay_r, decay_nxt, filt_r, filt_nxt;
    logic [TCW-1:0] tdiv_r, tdiv_nxt;
    logic tick_r, tick_nxt, burst_r, burst_nxt, relay_r, relay_nxt;
    logic [TIME_W-1:0] rcnt_r, rcnt_nxt, ccnt_r, ccnt_nxt, on_r, on_nxt, pts_r, pts_nxt;
    logic [SW-1:0] acc_r, acc_nxt;
    logic [P_DW-1:0] pval_r, pval_nxt, last_r, last_nxt, recv_r, recv_nxt;
    logic pbad_r, pbad_nxt, pfilt_r, pfilt_nxt, wait_r, wait_nxt, go_r, go_nxt;
    logic [SW-1:0] total_r, total_nxt;
    logic [TIME_W-1:0] feff_r, feff_nxt;
    logic lbad_r, lbad_nxt, rreq_r, rreq_nxt, rvld_r, rvld_nxt;
    logic [P_DW-1:0] val_r [P_NS], val_nxt [P_NS];
    logic [TIME_W-1:0] ts_r [P_NS], ts_nxt [P_NS];
    logic [P_NS-1:0] used_r, used_nxt, incl;
    logic [$clog2(P_NS)-1:0] wp_r, wp_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    // ****************************************
    // Combinational helpers
    // ****************************************
    logic start_ev, rec_ev, meas_ev, sup_on, acc_en, store, rec_fire;
    logic [TIME_W-1:0] thr, lead_gap;
    logic [CW-1:0] n_incl, tgt, rank;
    logic [P_DW-1:0] med;
    assign div_bus.go = go_r;
    assign div_bus.dividend = total_r;
    assign div_bus.divisor = {{P_DW{1'b0}}, feff_r};
    assign o_rdata = rdata_r;
    assign o_relay = relay_r;
    assign o_rec_valid = rvld_r;
    assign o_rec_value = recv_r;
    // Median: rank by value, ties broken by slot index
    always_comb begin
        n_incl = '0;
        med = '0;
        for (int i = 0; i < P_NS; i++) begin
            incl[i] = used_r[i] && ((rec_r - 1'b1 - ts_r[i]) < decay_r);
            n_incl = n_incl + CW'(incl[i]);
        end
        tgt = (n_incl - 1'b1) >> 1;
        for (int i = 0; i < P_NS; i++) begin
            rank = '0;
            for (int j = 0; j < P_NS; j++) begin
                if (incl[j] && (val_r[j] < val_r[i] || (val_r[j] == val_r[i] && j < i))) begin
                    rank = rank + 1'b1;
                end
            end
            if (incl[i] && rank == tgt) begin
                med = val_r[i];
            end
        end
    end

    always_comb begin
        mode_nxt = mode_r;
        {lead_nxt, cyc_nxt, blen_nxt, rec_nxt} = {lead_r, cyc_r, blen_r, rec_r};
        {setp_nxt, inv_nxt, decay_nxt, filt_nxt} = {setp_r, inv_r, decay_r, filt_r};
        val_nxt = val_r;
        ts_nxt = ts_r;
        used_nxt = used_r;
        wp_nxt = wp_r;
        // 1 ms time base
        tick_nxt = (tdiv_r == TCW'(P_TICK_CYCLES - 1));
        tdiv_nxt = tick_nxt ? '0 : tdiv_r + 1'b1;
        rec_ev = tick_r && (rcnt_r == rec_r - 1'b1);
        start_ev = tick_r && !burst_r && (blen_r < rec_r) && (rcnt_r == rec_r - blen_r - 1'b1);
        meas_ev = tick_r && burst_r && (ccnt_r == cyc_r - 1'b1);
        rcnt_nxt = tick_r ? (rec_ev ? '0 : rcnt_r + 1'b1) : rcnt_r;
        burst_nxt = start_ev ? 1'b1 : (rec_ev ? 1'b0 : burst_r);
        ccnt_nxt = ccnt_r;
        if (start_ev || meas_ev) begin
            ccnt_nxt = '0;
        end else if (tick_r && burst_r) begin
            ccnt_nxt = ccnt_r + 1'b1;
        end
        if (start_ev) begin
            used_nxt = '0;
            wp_nxt = '0;
        end
        // Supply scheduling
        lead_gap = cyc_r - lead_r;
        sup_on = (lead_r != '0) && burst_r && !rec_ev &&
            ((lead_r >= cyc_r) || (ccnt_r >= lead_gap));
        case (mode_r)
            RWM_OFF: relay_nxt = 1'b0;
            RWM_DIG: relay_nxt = setp_r ^ inv_r;
            RWM_WARM: relay_nxt = sup_on;
            default: relay_nxt = 1'b0;
        endcase
        on_nxt = !relay_r ? '0 : ((tick_r && on_r != '1) ? on_r + 1'b1 : on_r);
        // Filter window
        feff_nxt = (filt_r >= cyc_r) ? cyc_r : filt_r;
        thr = cyc_r - feff_nxt;
        acc_en = tick_r && burst_r && (filt_r != '0) && (ccnt_r >= thr);
        acc_nxt = meas_ev ? '0 : (acc_en ? acc_r + SW'(i_sample) : acc_r);
        total_nxt = total_r;
        go_nxt = 1'b0;
        {pval_nxt, pts_nxt, pbad_nxt, pfilt_nxt} = {pval_r, pts_r, pbad_r, pfilt_r};
        wait_nxt = wait_r;
        store = wait_r && (!pfilt_r || div_bus.done);
        if (meas_ev) begin
            total_nxt = acc_r + SW'(i_sample);
            go_nxt = (filt_r != '0);
            pfilt_nxt = (filt_r != '0);
            pval_nxt = i_sample;
            pts_nxt = rcnt_r;
            pbad_nxt = (mode_r == RWM_WARM) &&
                ({1'b0, on_r} + 1'b1 < {1'b0, lead_r});
            wait_nxt = 1'b1;
        end else if (store) begin
            wait_nxt = 1'b0;
        end
        last_nxt = last_r;
        lbad_nxt = lbad_r;
        if (store) begin
            last_nxt = pfilt_r ? div_bus.quot[P_DW-1:0] : pval_r;
            lbad_nxt = pbad_r;
            val_nxt[wp_r] = last_nxt;
            ts_nxt[wp_r] = pts_r;
            used_nxt[wp_r] = 1'b1;
            wp_nxt = wp_r + 1'b1;
        end
        // Record point waits for a pending sample
        rec_fire = rreq_r && !wait_r;
        rreq_nxt = rec_ev ? 1'b1 : (rec_fire ? 1'b0 : rreq_r);
        rvld_nxt = rec_fire && (n_incl != '0);
        recv_nxt = rvld_nxt ? med : recv_r;
        // Register port
        if (i_wr) begin
            case (i_addr)
                OFS_CTRL: begin
                    mode_nxt = rwm_mode_t'(i_wdata[CTRL_MODE_LSB +: 2]);
                    setp_nxt = i_wdata[CTRL_SETP_BIT];
                    inv_nxt = i_wdata[CTRL_INV_BIT];
                end
                OFS_LEAD: lead_nxt = i_wdata[TIME_W-1:0];
                OFS_CYCLE: cyc_nxt = i_wdata[TIME_W-1:0];
                OFS_BURST: blen_nxt = i_wdata[TIME_W-1:0];
                OFS_RECORD: rec_nxt = i_wdata[TIME_W-1:0];
                OFS_DECAY: decay_nxt = i_wdata[TIME_W-1:0];
                OFS_FILTER: filt_nxt = i_wdata[TIME_W-1:0];
                default: ;
            endcase
        end
        rdata_nxt = '0;
        if (i_rd) begin
            case (i_addr)
                OFS_CTRL: rdata_nxt = DATA_W'({inv_r, setp_r, mode_r});
                OFS_LEAD: rdata_nxt = DATA_W'(lead_r);
                OFS_CYCLE: rdata_nxt = DATA_W'(cyc_r);
                OFS_BURST: rdata_nxt = DATA_W'(blen_r);
                OFS_RECORD: rdata_nxt = DATA_W'(rec_r);
                OFS_DECAY: rdata_nxt = DATA_W'(decay_r);
                OFS_FILTER: rdata_nxt = DATA_W'(filt_r);
                OFS_STATUS: rdata_nxt = DATA_W'({wait_r, lbad_r, burst_r, relay_r});
                OFS_RESULT: rdata_nxt = DATA_W'(recv_r);
                OFS_LAST: rdata_nxt = DATA_W'(last_r);
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_r <= RWM_OFF;
            {lead_r, cyc_r, blen_r, rec_r} <= {RST_LEAD, RST_CYCLE, RST_BURST, RST_RECORD};
            {setp_r, inv_r, decay_r, filt_r} <= {2'b00, RST_DECAY, RST_FILTER};
            {tdiv_r, tick_r, burst_r, relay_r} <= '0;
            {rcnt_r, ccnt_r, on_r, pts_r, acc_r, total_r, feff_r} <= '0;
            {pval_r, last_r, recv_r, pbad_r, pfilt_r, wait_r, go_r} <= '0;
            {lbad_r, rreq_r, rvld_r, used_r, wp_r, rdata_r} <= '0;
            for (int i = 0; i < P_NS; i++) begin
                val_r[i] <= '0;
                ts_r[i] <= '0;
            end
        end else begin
            mode_r <= mode_nxt;
            {lead_r, cyc_r, blen_r, rec_r} <= {lead_nxt, cyc_nxt, blen_nxt, rec_nxt};
            {setp_r, inv_r, decay_r, filt_r} <= {setp_nxt, inv_nxt, decay_nxt, filt_nxt};
            {tdiv_r, tick_r, burst_r, relay_r} <= {tdiv_nxt, tick_nxt, burst_nxt, relay_nxt};
            {rcnt_r, ccnt_r, on_r, pts_r} <= {rcnt_nxt, ccnt_nxt, on_nxt, pts_nxt};
            {acc_r, total_r, feff_r} <= {acc_nxt, total_nxt, feff_nxt};
            {pval_r, last_r, recv_r} <= {pval_nxt, last_nxt, recv_nxt};
            {pbad_r, pfilt_r, wait_r, go_r} <= {pbad_nxt, pfilt_nxt, wait_nxt, go_nxt};
            {lbad_r, rreq_r, rvld_r} <= {lbad_nxt, rreq_nxt, rvld_nxt};
            {used_r, wp_r, rdata_r} <= {used_nxt, wp_nxt, rdata_nxt};
            val_r <= val_nxt;
            ts_r <= ts_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_off;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (mode_r == RWM_OFF) |=> !o_relay;
    endproperty
    a_off: assert property (p_off) else $error("relay high in off mode");
    property p_dig;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (mode_r == RWM_DIG) |=> (o_relay == ($past(setp_r) ^ $past(inv_r)));
    endproperty
    a_dig: assert property (p_dig) else $error("digital level wrong");
    property p_zero;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (mode_r == RWM_WARM && lead_r == '0) |=> !o_relay;
    endproperty
    a_zero: assert property (p_zero) else $error("relay on with zero lead");
    property p_long;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (mode_r == RWM_WARM && lead_r != '0 && lead_r >= cyc_r && burst_r && !rec_ev)
            |=> o_relay;
    endproperty
    a_long: assert property (p_long) else $error("supply off inside burst");
    property p_short;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (mode_r == RWM_WARM && lead_r != '0 && lead_r < cyc_r && burst_r && !rec_ev)
            |=> (o_relay == ($past(ccnt_r) >= $past(cyc_r) - $past(lead_r)));
    endproperty
    a_short: assert property (p_short) else $error("supply edge not at lead");
    property p_meas;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        start_ev |=> (ccnt_r == '0) && burst_r;
    endproperty
    a_meas: assert property (p_meas) else $error("burst start misaligned");
    property p_bad;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (meas_ev && mode_r == RWM_WARM && lead_r > cyc_r && ccnt_r < lead_r && on_r < cyc_r)
            |=> pbad_r;
    endproperty
    a_bad: assert property (p_bad) else $error("early sample not invalid");
    property p_rec;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (rec_fire && n_incl != '0) |=> o_rec_valid && (o_rec_value == $past(med));
    endproperty
    a_rec: assert property (p_rec) else $error("median not recorded");
    property p_decay;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (rec_fire && n_incl == '0) |=> !o_rec_valid;
    endproperty
    a_decay: assert property (p_decay) else $error("record with empty window");
    property p_filt;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        meas_ev && filt_r != '0 |=> go_r ##[1:40] div_bus.done;
    endproperty
    a_filt: assert property (p_filt) else $error("filter average not formed");
endmodule // rwm_top

// file: hdl/rwm_pkg.sv
// Shared constants for the relay warm-up and measurement sequencer.
// Assumes a single 100 MHz system clock and a 1 ms internal time base.
package rwm_pkg;
    // ****************************************
    // Bus and widths
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TIME_W = 20;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LEAD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CYCLE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_BURST = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_RECORD = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DECAY = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_FILTER = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_LAST = 8'h24;
    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SETP_BIT = 2;
    localparam int CTRL_INV_BIT = 3;
    localparam int ST_RELAY_BIT = 0;
    localparam int ST_BURST_BIT = 1;
    localparam int ST_BAD_BIT = 2;
    localparam int ST_BUSY_BIT = 3;
    localparam logic [TIME_W-1:0] RST_LEAD = 20'h01388;
    localparam logic [TIME_W-1:0] RST_CYCLE = 20'h03a98;
    localparam logic [TIME_W-1:0] RST_BURST = 20'h0ea60;
    localparam logic [TIME_W-1:0] RST_RECORD = 20'h493e0;
    localparam logic [TIME_W-1:0] RST_DECAY = 20'h0ea60;
    localparam logic [TIME_W-1:0] RST_FILTER = 20'h00000;
    typedef enum logic [1:0] {
        RWM_OFF,
        RWM_WARM,
        RWM_DIG
    } rwm_mode_t;
endpackage

// file: hdl/rwm_div_if.sv
// Request and answer bundle between the sequencer and its divider.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface rwm_div_if #(parameter int W = 36);
    logic go;
    logic [W-1:0] dividend;
    logic [W-1:0] divisor;
    logic done;
    logic [W-1:0] quot;
    modport master (output go, output dividend, output divisor, input done, input quot);
    modport slave (input go, input dividend, input divisor, output done, output quot);
endinterface

// file: hdl/rwm_div.sv
// Restoring divider, one quotient bit per clock.
// Assumes go is a one-cycle pulse and divisor is non-zero.
`timescale 1ns/1ps
module rwm_div #(
    parameter int W = 36
) (
    input wire logic i_sys_clk, // System clock
    input wire logic i_rst_n,   // Async reset, active low
    rwm_div_if.slave bus        // Divide request and answer
);
    logic [W:0] rem_r, rem_nxt, sh;
    logic [W-1:0] quo_r, quo_nxt, dvs_r, dvs_nxt;
    logic [$clog2(W+1)-1:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt, done_r, done_nxt;
    if (W < 2) begin : g_chk
        $error("rwm_div: width below 2");
    end

    assign bus.done = done_r;
    assign bus.quot = quo_r;

    always_comb begin
        rem_nxt = rem_r;
        quo_nxt = quo_r;
        dvs_nxt = dvs_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        sh = {rem_r[W-1:0], quo_r[W-1]};
        if (bus.go) begin
            rem_nxt = '0;
            quo_nxt = bus.dividend;
            dvs_nxt = bus.divisor;
            cnt_nxt = ($clog2(W+1))'(W);
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            quo_nxt = {quo_r[W-2:0], 1'b0};
            rem_nxt = sh;
            if (sh >= {1'b0, dvs_r}) begin
                rem_nxt = sh - {1'b0, dvs_r};
                quo_nxt[0] = 1'b1;
            end
            cnt_nxt = cnt_r - 1'b1;
            if (cnt_r == 1) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rem_r <= '0;
            quo_r <= '0;
            dvs_r <= '0;
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            rem_r <= rem_nxt;
            quo_r <= quo_nxt;
            dvs_r <= dvs_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end
endmodule // rwm_div

// file: verif/rwm_sensor.sv
// Behavioural sensor powered from the relay or supply output.
// Assumes power comes from o_relay on the same system clock.
`timescale 1ns/1ps
module rwm_sensor (
    input wire logic i_sys_clk,       // System clock
    input wire logic i_rst_n,         // Async reset, active low
    input wire logic i_power,         // Supply from relay
    input wire logic [15:0] i_level,  // Settled reading
    input wire logic [31:0] i_settle, // Powered clocks until stable
    output logic [15:0] o_value       // Reading to converter
);
    logic [31:0] on_r;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            on_r <= '0;
            o_value <= 16'h5a5a;
        end else if (!i_power) begin
            on_r <= '0;
            o_value <= ~o_value; // Unpowered, no stable level
        end else begin
            on_r <= on_r + 32'h1;
            o_value <= (on_r < i_settle) ? 16'hfff0 : i_level;
        end
    end
endmodule // rwm_sensor

// file: verif/rwm_top_tb.sv
// Self-checking bench for the relay warm-up and measurement sequencer.
// Assumes a shortened tick of 10 clocks per millisecond.
`timescale 1ns/1ps
module rwm_top_tb;
    import rwm_pkg::*;
    localparam int TK = 10;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [DATA_W-1:0] o_rdata;
    logic [15:0] i_sample, o_rec_value, rec_v;
    logic [15:0] level = 16'h1000;
    logic o_relay, o_rec_valid;
    logic relay_q = 1'b0;
    logic clr = 1'b0;
    logic [31:0] settle = 32'd25;
    logic [31:0] rd_v, cyc = 0, last_rise = 0, gap = 0, rises = 0;
    logic [31:0] on_cur = 0, on_min = 0, on_max = 0;
    logic [7:0] rofs [6] = '{OFS_LEAD, OFS_CYCLE, OFS_BURST, OFS_RECORD, OFS_DECAY, OFS_FILTER};
    logic [19:0] rval [6] = '{RST_LEAD, RST_CYCLE, RST_BURST, RST_RECORD, RST_DECAY, RST_FILTER};
    int error_cnt = 0;
    int checks_done = 0;
    always #5 i_sys_clk = ~i_sys_clk;
    rwm_top #(.P_TICK_CYCLES(TK)) uut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sample(i_sample),
        .o_relay(o_relay), .o_rec_valid(o_rec_valid), .o_rec_value(o_rec_value)
    );
    rwm_sensor sensor (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_power(o_relay),
        .i_level(level), .i_settle(settle), .o_value(i_sample)
    );
    // ****************************************
    // Relay on-time and spacing monitor
    // ****************************************
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        relay_q <= o_relay;
        on_cur <= o_relay ? on_cur + 1 : 32'h0;
        if (clr) begin
            rises <= 0;
            on_min <= 32'hffff;
            on_max <= 0;
        end else begin
            if (o_relay && !relay_q) begin
                rises <= rises + 1;
                gap <= cyc - last_rise;
                last_rise <= cyc;
            end
            if (!o_relay && relay_q) begin
                if (on_cur < on_min) on_min <= on_cur;
                if (on_cur > on_max) on_max <= on_cur;
            end
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask
    task automatic wait_rec(input logic must);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        #1;
        while (o_rec_valid !== 1'b1 && n < 1300) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        rec_v = o_rec_value;
        if (must) chk({31'h0, o_rec_valid}, 32'h1, "record pulse");
    endtask
    task automatic run(input logic [19:0] ld, bu, dc, fl, input logic [31:0] st);
        settle <= st;
        wr(OFS_RECORD, 32'd100);
        wr(OFS_CYCLE, 32'd15);
        wr(OFS_LEAD, {12'h0, ld});
        wr(OFS_BURST, {12'h0, bu});
        wr(OFS_DECAY, {12'h0, dc});
        wr(OFS_FILTER, {12'h0, fl});
        wr(OFS_CTRL, 32'h1);
        wait_rec(1'b0);
        clr = 1'b1;
        @(posedge i_sys_clk);
        #1;
        clr = 1'b0;
        wait_rec(1'b1);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            rd(rofs[k], rd_v);
            chk(rd_v, {12'h0, rval[k]}, "reset value");
        end
        rd(OFS_CTRL, rd_v);
        chk(rd_v, 32'h0, "control reset");
        rd(8'h40, rd_v);
        chk(rd_v, 32'h0, "unmapped read");
        wr(OFS_LEAD, 32'hfff0_0007);
        rd(OFS_LEAD, rd_v);
        chk(rd_v, 32'h7, "time field width");
        for (int k = 0; k < 4; k++) begin
            wr(OFS_CTRL, {28'h0, k[1], k[0], 2'd2});
            repeat (2) @(posedge i_sys_clk);
            #1;
            chk({31'h0, o_relay}, {31'h0, k[1] ^ k[0]}, "digital level");
        end
        for (int m = 0; m < 4; m += 3) begin
            wr(OFS_CTRL, 32'h4 | m);
            repeat (2) @(posedge i_sys_clk);
            #1;
            chk({31'h0, o_relay}, 32'h0, "off mode level");
        end
        run(20'd0, 20'd60, 20'd60, 20'd0, 32'd25);
        chk(rises | on_max, 32'h0, "zero lead relay");
        run(20'd5, 20'd60, 20'd60, 20'd0, 32'd25);
        chk({31'h0, on_min >= 48 && on_max <= 52}, 32'h1, "lead on time");
        chk(rises, 32'd4, "measurements per burst");
        chk({31'h0, gap >= 148 && gap <= 152}, 32'h1, "cycle spacing");
        chk({16'h0, rec_v}, {16'h0, level}, "median value");
        run(20'd5, 20'd60, 20'd60, 20'd4, 32'd25);
        chk({16'h0, rec_v}, (32'hfff0 + 3 * 32'h1000) / 4, "filter average");
        run(20'd30, 20'd75, 20'd50, 20'd0, 32'd500);
        chk({31'h0, on_max >= 748 && on_max <= 752}, 32'h1, "burst-long supply");
        chk(rises, 32'd1, "single supply pulse");
        chk({16'h0, rec_v}, {16'h0, level}, "decay window median");
        rd(OFS_RESULT, rd_v);
        chk(rd_v, {16'h0, level}, "result register");
        finish_test();
    end
    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end
endmodule // rwm_top_tb
